// file: rtl/vias_pkg.sv
// constants, types and field layout of the vectored interrupt acknowledge sequencer
// ====================================================================
`default_nettype none
package vias_pkg;
    // ====================================================================
    // host port selection
    localparam logic        PORT_CMD     = 1'h0;   // command and status port
    localparam logic        PORT_MASK    = 1'h1;   // mask and init port
    // ====================================================================
    // command decode bit positions on port 0
    localparam int          CMD_SEL_HI   = 4;      // set: init word one
    localparam int          CMD_SEL_LO   = 3;      // 0: word two, 1: word three
    // init word one fields
    localparam int          W1_NEED_W4   = 0;
    localparam int          W1_SINGLE    = 1;
    localparam int          W1_SPACING4  = 2;
    localparam int          W1_LEVEL     = 3;
    localparam int          W1_ADDR_LSB  = 5;
    // init word four fields
    localparam int          W4_PTR_MODE  = 0;
    localparam int          W4_AUTO_EOS  = 1;
    localparam int          W4_MASTER    = 2;
    localparam int          W4_BUFFERED  = 3;
    localparam int          W4_NESTED    = 4;
    // operation word two and three fields
    localparam int          W2_EOS       = 5;
    localparam int          W2_SPECIFIC  = 6;
    localparam int          W3_READ_ISR  = 0;
    localparam int          W3_READ_SET  = 1;
    // ====================================================================
    // acknowledge output patterns and reset values
    localparam logic [7:0]  CALL_OPCODE  = 8'hcd;  // 1100 1101
    localparam logic [2:0]  LEVEL_LOWEST = 3'h7;   // answer for a vanished request
    localparam logic [7:0]  MASK_RESET   = 8'h00;
    localparam logic [7:0]  BITS_RESET   = 8'h00;
    localparam logic [7:0]  BUS_IDLE     = 8'h00;
    localparam logic [1:0]  PULSE_NONE   = 2'h0;
    localparam logic [1:0]  PULSE_FIRST  = 2'h1;
    localparam logic [1:0]  PULSE_SECOND = 2'h2;
    localparam logic [1:0]  PULSE_THIRD  = 2'h3;
    // ====================================================================
    // programmed configuration carried as one word
    typedef struct packed {
        logic [2:0] addr_lo;      // vector address bits 7..5
        logic       level_trig;   // level triggered requests
        logic       spacing4;     // call spacing of four
        logic       single;       // no cascade word expected
        logic       need_w4;      // init word four follows
        logic [7:0] upper;        // upper address or pointer type bits
        logic       nested;       // special fully nested
        logic       buffered;     // buffered operation
        logic       master;       // buffered master
        logic       auto_eos;     // automatic end of service
        logic       ptr_mode;     // two-pulse pointer mode
    } vias_cfg_s;
    localparam vias_cfg_s   CFG_RESET    = '0;
    // initialisation progress
    typedef enum logic [2:0] {
        ST_WAIT_W1,
        ST_WAIT_W2,
        ST_WAIT_W3,
        ST_WAIT_W4,
        ST_READY
    } vias_init_e;
endpackage : vias_pkg
`default_nettype wire

// file: rtl/vias_prio.sv
// fixed priority finder: lowest set index wins
`timescale 1ns/100ps
`default_nettype none
module vias_prio #(
    parameter int WIDTH = 8,
    parameter int IDXW  = 3
) (
    // vector in
    input  wire logic [WIDTH-1:0] i_vec,
    // result out
    output logic                  o_valid,
    output logic [IDXW-1:0]       o_idx
);
    // ====================================================================
    // parameter check
    initial begin
        if ((1 << IDXW) < WIDTH) begin
            $error("index width too small for vector");
        end
    end
    // ====================================================================
    // scan from the lowest priority upward so bit 0 is kept last
    always_comb begin
        o_valid = 1'b0;
        o_idx   = '0;
        for (int k = WIDTH - 1; k >= 0; k--) begin
            if (i_vec[k]) begin
                o_valid = 1'b1;
                o_idx   = IDXW'(k);
            end
        end
    end
endmodule : vias_prio
`default_nettype wire

// file: rtl/vias_vec_fmt.sv
// forms the byte returned during each acknowledge pulse
`timescale 1ns/100ps
`default_nettype none
module vias_vec_fmt
    import vias_pkg::*;
(
    // selection
    input  wire vias_cfg_s  i_cfg,
    input  wire logic [1:0] i_pulse,
    input  wire logic [2:0] i_level,
    // result
    output logic [7:0]      o_byte,
    output logic            o_drive
);
    // ====================================================================
    // byte per pulse number and processor mode
    always_comb begin
        o_byte  = BUS_IDLE;
        o_drive = 1'b0;
        if (i_cfg.ptr_mode) begin
            // first pulse stays released, second gives the pointer
            if (i_pulse == PULSE_SECOND) begin
                o_byte  = {i_cfg.upper[7:3], i_level};
                o_drive = 1'b1;
            end
        end else begin
            case (i_pulse)
                PULSE_FIRST: begin
                    o_byte  = CALL_OPCODE;
                    o_drive = 1'b1;
                end
                PULSE_SECOND: begin
                    // level placement follows the call spacing
                    if (i_cfg.spacing4) begin
                        o_byte = {i_cfg.addr_lo, i_level, 2'h0};
                    end else begin
                        o_byte = {i_cfg.addr_lo[2:1], i_level, 3'h0};
                    end
                    o_drive = 1'b1;
                end
                PULSE_THIRD: begin
                    o_byte  = i_cfg.upper;
                    o_drive = 1'b1;
                end
                default: begin
                    o_byte  = BUS_IDLE;
                    o_drive = 1'b0;
                end
            endcase
        end
    end
endmodule : vias_vec_fmt
`default_nettype wire

// file: rtl/vias_top.sv
// eight-level interrupt controller: host port, request latch and acknowledge sequence
`timescale 1ns/100ps
`default_nettype none
module vias_top
    import vias_pkg::*;
#(
    parameter int NUM_LEVELS = 8
) (
    // clock, reset and enable
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    input  wire logic       i_ce,
    // host port strobes
    input  wire logic       i_cs_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic       i_port_select,
    input  wire logic       i_acknowledge_strobe_n,
    // data bus, split into three signals
    input  wire logic [7:0] i_data,
    output logic      [7:0] o_data,
    output logic            o_data_oe_n,
    // request inputs and interrupt output
    input  wire logic [7:0] i_request_inputs,
    output logic            o_int
);
    // ====================================================================
    // parameter check
    initial begin
        if (NUM_LEVELS != 8) begin
            $error("only eight request levels are supported");
        end
    end

    // ====================================================================
    // state declarations
    vias_cfg_s  cfg;                  // programmed configuration
    vias_cfg_s  next_cfg;
    vias_init_e init_state;           // initialisation progress
    vias_init_e next_init_state;
    logic [7:0] request_mask;         // mask, set bit blocks a level
    logic [7:0] next_request_mask;
    logic       read_isr;             // status read selects in-service bits
    logic       next_read_isr;
    logic [7:0] request_latch;        // latched requests
    logic [7:0] next_request_latch;
    logic [7:0] in_service_bits;      // levels being served
    logic [7:0] next_in_service_bits;
    logic [1:0] pulse;                // acknowledge pulse number, 0 when idle
    logic [1:0] next_pulse;
    logic [2:0] ack_level;            // level frozen at the first pulse
    logic [2:0] next_ack_level;
    logic       spurious;             // request vanished before first pulse
    logic       next_spurious;
    logic       wr_n_q;               // previous write strobe
    logic       ack_n_q;              // previous acknowledge strobe
    logic [7:0] req_q;                // previous request inputs
    logic [7:0] next_data;
    logic       next_data_oe_n;
    logic       next_int;

    // ====================================================================
    // decode of host strobes
    logic       wr_take;              // leading edge of a selected write
    logic       wr_cmd_w1;            // init word one
    logic       wr_cmd_w2;            // operation word two
    logic       wr_cmd_w3;            // operation word three
    logic       wr_port1;             // mask or remaining init words
    logic       rd_sel;               // selected read in progress
    logic       ack_lead;             // acknowledge falling edge
    logic       ack_trail;            // acknowledge rising edge
    logic [1:0] last_pulse;           // final pulse number of the mode

    assign wr_take   = ~i_cs_n & i_rd_n & ~i_wr_n & wr_n_q;
    assign wr_cmd_w1 = wr_take & (i_port_select == PORT_CMD) & i_data[CMD_SEL_HI];
    assign wr_cmd_w2 = wr_take & (i_port_select == PORT_CMD) & ~i_data[CMD_SEL_HI]
                     & ~i_data[CMD_SEL_LO];
    assign wr_cmd_w3 = wr_take & (i_port_select == PORT_CMD) & ~i_data[CMD_SEL_HI]
                     & i_data[CMD_SEL_LO];
    assign wr_port1  = wr_take & (i_port_select == PORT_MASK);
    assign rd_sel    = ~i_cs_n & ~i_rd_n & i_wr_n;
    assign ack_lead  = ~i_acknowledge_strobe_n & ack_n_q;
    assign ack_trail = i_acknowledge_strobe_n & ~ack_n_q;
    assign last_pulse = cfg.ptr_mode ? PULSE_SECOND : PULSE_THIRD;

    // ====================================================================
    // priority resolution
    logic       pend_valid;           // any unmasked latched request
    logic [2:0] pend_idx;             // highest pending level
    logic       serv_valid;           // any level in service
    logic [2:0] serv_idx;             // highest level in service
    logic       int_ok;               // pending level outranks service

    // highest unmasked request
    vias_prio #(
        .WIDTH (8),
        .IDXW  (3)
    ) u_prio_pend (
        .i_vec   (request_latch & ~request_mask),
        .o_valid (pend_valid),
        .o_idx   (pend_idx)
    );

    // highest level in service
    vias_prio #(
        .WIDTH (8),
        .IDXW  (3)
    ) u_prio_serv (
        .i_vec   (in_service_bits),
        .o_valid (serv_valid),
        .o_idx   (serv_idx)
    );

    // nested mode lets an equal level through as well
    always_comb begin
        int_ok = 1'b0;
        if (pend_valid) begin
            if (!serv_valid) begin
                int_ok = 1'b1;
            end else if (pend_idx < serv_idx) begin
                int_ok = 1'b1;
            end else if (cfg.nested && (pend_idx == serv_idx)) begin
                int_ok = 1'b1;
            end
        end
    end

    // ====================================================================
    // host configuration: next values
    always_comb begin
        next_cfg          = cfg;
        next_init_state   = init_state;
        next_request_mask = request_mask;
        next_read_isr     = read_isr;
        if (wr_cmd_w1) begin
            // word one restarts initialisation
            next_cfg.addr_lo    = i_data[W1_ADDR_LSB +: 3];
            next_cfg.level_trig = i_data[W1_LEVEL];
            next_cfg.spacing4   = i_data[W1_SPACING4];
            next_cfg.single     = i_data[W1_SINGLE];
            next_cfg.need_w4    = i_data[W1_NEED_W4];
            if (!i_data[W1_NEED_W4]) begin
                // word four skipped: its fields read as zero
                next_cfg.nested   = 1'b0;
                next_cfg.buffered = 1'b0;
                next_cfg.master   = 1'b0;
                next_cfg.auto_eos = 1'b0;
                next_cfg.ptr_mode = 1'b0;
            end
            next_request_mask = MASK_RESET;
            next_read_isr     = 1'b0;
            next_init_state   = ST_WAIT_W2;
        end else if (wr_cmd_w3) begin
            // status read selection
            if (i_data[W3_READ_SET]) begin
                next_read_isr = i_data[W3_READ_ISR];
            end
        end else if (wr_port1) begin
            case (init_state)
                ST_WAIT_W2: begin
                    next_cfg.upper = i_data;
                    if (!cfg.single) begin
                        next_init_state = ST_WAIT_W3;
                    end else if (cfg.need_w4) begin
                        next_init_state = ST_WAIT_W4;
                    end else begin
                        next_init_state = ST_READY;
                    end
                end
                ST_WAIT_W3: begin
                    // cascade word has no effect in this block
                    next_init_state = cfg.need_w4 ? ST_WAIT_W4 : ST_READY;
                end
                ST_WAIT_W4: begin
                    next_cfg.nested   = i_data[W4_NESTED];
                    next_cfg.buffered = i_data[W4_BUFFERED];
                    next_cfg.master   = i_data[W4_MASTER];
                    next_cfg.auto_eos = i_data[W4_AUTO_EOS];
                    next_cfg.ptr_mode = i_data[W4_PTR_MODE];
                    next_init_state   = ST_READY;
                end
                ST_READY: begin
                    next_request_mask = i_data;               // operation word one
                end
                default: begin
                    next_init_state = ST_WAIT_W1;
                end
            endcase
        end
    end

    // host configuration: registers
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cfg          <= CFG_RESET;
            init_state   <= ST_WAIT_W1;
            request_mask <= MASK_RESET;
            read_isr     <= 1'b0;
        end else if (i_ce) begin
            cfg          <= next_cfg;
            init_state   <= next_init_state;
            request_mask <= next_request_mask;
            read_isr     <= next_read_isr;
        end
    end

    // ====================================================================
    // requests, service bits and acknowledge sequence: next values
    logic [7:0] req_set;              // latch set terms per level
    logic [7:0] req_clr;              // latch clear terms per level
    logic [7:0] serv_set;
    logic [7:0] serv_clr;

    always_comb begin
        next_pulse     = pulse;
        next_ack_level = ack_level;
        next_spurious  = spurious;
        req_set        = BITS_RESET;
        req_clr        = BITS_RESET;
        serv_set       = BITS_RESET;
        serv_clr       = BITS_RESET;
        // edge mode catches a rise, level mode follows the input
        if (cfg.level_trig) begin
            req_set = i_request_inputs;
            req_clr = ~i_request_inputs;
        end else begin
            req_set = i_request_inputs & ~req_q;
        end
        if (ack_lead) begin
            next_pulse = pulse + 2'h1;
            if (pulse == PULSE_NONE) begin
                // freeze the level; a vanished request answers as level seven
                if (int_ok && i_request_inputs[pend_idx]) begin
                    next_ack_level = pend_idx;
                    next_spurious  = 1'b0;
                end else begin
                    next_ack_level = LEVEL_LOWEST;
                    next_spurious  = 1'b1;
                end
            end
            if ((next_pulse == last_pulse) && !next_spurious) begin
                serv_set[next_ack_level] = 1'b1;
                req_clr[next_ack_level]  = 1'b1;
            end
        end
        if (ack_trail && (pulse == last_pulse)) begin
            next_pulse = PULSE_NONE;
            if (cfg.auto_eos && !spurious) begin
                serv_clr[ack_level] = 1'b1;
            end
        end
        if (wr_cmd_w2 && i_data[W2_EOS]) begin
            // specific end names a level, otherwise the highest in service
            if (i_data[W2_SPECIFIC]) begin
                serv_clr[i_data[2:0]] = 1'b1;
            end else if (serv_valid) begin
                serv_clr[serv_idx] = 1'b1;
            end
        end
        // a set in the same cycle as a clear wins
        next_request_latch   = (request_latch & ~req_clr) | req_set;
        next_in_service_bits = (in_service_bits & ~serv_clr) | serv_set;
        if (wr_cmd_w1) begin
            next_pulse = PULSE_NONE;
        end
    end

    // requests, service bits and acknowledge sequence: registers
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            request_latch   <= BITS_RESET;
            in_service_bits <= BITS_RESET;
            pulse           <= PULSE_NONE;
            ack_level       <= LEVEL_LOWEST;
            spurious        <= 1'b0;
            wr_n_q          <= 1'b1;
            ack_n_q         <= 1'b1;
            req_q           <= BITS_RESET;
        end else if (i_ce) begin
            request_latch   <= next_request_latch;
            in_service_bits <= next_in_service_bits;
            pulse           <= next_pulse;
            ack_level       <= next_ack_level;
            spurious        <= next_spurious;
            wr_n_q          <= i_wr_n;
            ack_n_q         <= i_acknowledge_strobe_n;
            req_q           <= i_request_inputs;
        end
    end

    // ====================================================================
    // acknowledge byte for the pulse now low
    logic [7:0] ack_byte;
    logic       ack_drive;

    vias_vec_fmt u_fmt (
        .i_cfg   (cfg),
        .i_pulse (ack_lead ? next_pulse : pulse),
        .i_level (ack_lead ? next_ack_level : ack_level),
        .o_byte  (ack_byte),
        .o_drive (ack_drive)
    );

    // ====================================================================
    // bus and interrupt outputs: next values
    always_comb begin
        next_data      = BUS_IDLE;
        next_data_oe_n = 1'b1;
        next_int       = int_ok & (init_state == ST_READY);
        if (!i_acknowledge_strobe_n) begin
            // pointer mode first pulse gives no drive
            next_data      = ack_byte;
            next_data_oe_n = ~ack_drive;
        end else if (rd_sel) begin
            if (i_port_select == PORT_CMD) begin
                next_data = read_isr ? in_service_bits : request_latch;
            end else begin
                next_data = request_mask;
            end
            next_data_oe_n = 1'b0;
        end
    end

    // bus and interrupt outputs: registers
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_data      <= BUS_IDLE;
            o_data_oe_n <= 1'b1;
            o_int       <= 1'b0;
        end else if (i_ce) begin
            o_data      <= next_data;
            o_data_oe_n <= next_data_oe_n;
            o_int       <= next_int;
        end
    end
endmodule : vias_top
`default_nettype wire

// file: tb/vias_chk.sv
// checker: host port release, read drive, interrupt output and pulse stability
`timescale 1ns/100ps
`default_nettype none
module vias_chk #(
    parameter int NUM_LEVELS = 8
) (
    input wire logic       i_clk,
    input wire logic       i_nrst,
    input wire logic       i_cs_n,
    input wire logic       i_rd_n,
    input wire logic       i_wr_n,
    input wire logic       i_acknowledge_strobe_n,
    input wire logic [7:0] i_request_inputs,
    input wire logic [7:0] o_data,
    input wire logic       o_data_oe_n,
    input wire logic       o_int
);
    logic seen_req; // a request line was high since reset
    always_ff @(posedge i_clk) seen_req <= i_nrst & (seen_req | (|i_request_inputs));
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    sequence s_ack_low;
        !i_acknowledge_strobe_n [*3];
    endsequence
    sequence s_rd_on;
        !i_cs_n && !i_rd_n && i_wr_n && i_acknowledge_strobe_n;
    endsequence
    chk_read_drive: assert property (s_rd_on |=> !o_data_oe_n)
        else $error("read not driven");
    chk_deselect_release: assert property (i_cs_n && i_acknowledge_strobe_n |=> o_data_oe_n)
        else $error("bus driven while deselected");
    chk_idle_release: assert property (!i_cs_n && i_rd_n && i_wr_n && i_acknowledge_strobe_n
        |=> o_data_oe_n)
        else $error("bus driven while idle");
    chk_write_quiet: assert property (!i_cs_n && !i_wr_n && i_acknowledge_strobe_n |=> o_data_oe_n)
        else $error("bus driven during write");
    chk_released_zero: assert property (o_data_oe_n |-> o_data == 8'h00)
        else $error("released bus not idle");
    chk_int_reset: assert property ($rose(i_nrst) |-> !o_int)
        else $error("interrupt out of reset");
    chk_int_cause: assert property (o_int |-> seen_req)
        else $error("interrupt without request");
    chk_ack_stable: assert property (s_ack_low |-> $stable(o_data) && $stable(o_data_oe_n))
        else $error("pulse output moved");
endmodule : vias_chk
`default_nettype wire

// file: tb/vias_host.sv
// host processor model: register strobes and acknowledge pulses
`timescale 1ns/100ps
`default_nettype none
module vias_host (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_data,
    input  wire logic       i_oe_n,
    output logic            o_cs_n,
    output logic            o_rd_n,
    output logic            o_wr_n,
    output logic            o_ps,
    output logic            o_ack_n,
    output logic [7:0]      o_data
);
    initial {o_cs_n, o_rd_n, o_wr_n, o_ack_n, o_ps, o_data} = {5'h1e, 8'h00};
    // one write, chip select held one idle cycle after the strobe
    task automatic wr(input logic ps, input logic [7:0] d);
        @(negedge i_clk) {o_cs_n, o_wr_n, o_ps, o_data} = {2'b00, ps, d};
        @(negedge i_clk) {o_wr_n, o_data} = {1'b1, ~d}; // released bus shows inverse
        @(negedge i_clk) o_cs_n = 1'b1;
    endtask : wr
    task automatic rd(input logic ps, output logic [7:0] q);
        @(negedge i_clk) {o_cs_n, o_rd_n, o_ps} = {2'b00, ps};
        repeat (2) @(negedge i_clk);
        q = i_oe_n ? ~i_data : i_data; // released bus reads as the inverse
        {o_cs_n, o_rd_n} = 2'b11;
    endtask : rd
    // one acknowledge pulse of three cycles; caller issues three or two
    task automatic ack(output logic [7:0] q, output logic oe_n);
        @(negedge i_clk) o_ack_n = 1'b0;
        repeat (3) @(negedge i_clk);
        {q, oe_n} = {i_oe_n ? ~i_data : i_data, i_oe_n};
        o_ack_n = 1'b1;
    endtask : ack
endmodule : vias_host
`default_nettype wire

// file: tb/tb.sv
// self-checking bench of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t %h %h", $time, a, b); end end
module tb;
    logic       i_clk, i_nrst, v, pm, ae, sp, oe, cs_n, rd_n, wr_n, ps, ack_n, oe_n, o_int;
    logic       lt, es, ce; // level trigger, specific end, clock enable
    logic [7:0] req, q, up, wdat, rdat;
    logic [2:0] a, lv;
    int         err_total, total_checks;
    vias_top vias_top_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(ce), .i_cs_n(cs_n),
        .i_rd_n(rd_n), .i_wr_n(wr_n), .i_port_select(ps), .i_acknowledge_strobe_n(ack_n),
        .i_data(wdat), .o_data(rdat), .o_data_oe_n(oe_n), .i_request_inputs(req), .o_int(o_int));
    vias_host vias_host_inst (.i_clk(i_clk), .i_data(rdat), .i_oe_n(oe_n), .o_cs_n(cs_n),
        .o_rd_n(rd_n), .o_wr_n(wr_n), .o_ps(ps), .o_ack_n(ack_n), .o_data(wdat));
    // low address byte by call spacing
    function automatic logic [7:0] lo(input logic [2:0] b, input logic s, input logic [2:0] l);
        return s ? {b, l, 2'b00} : {b[2:1], l, 3'b000};
    endfunction : lo
    task automatic complete_run();
        if (err_total == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        #300us;
        err_total++;
        complete_run();
    end
    initial begin
        {i_nrst, req} = 9'h000;
        ce = 1'b1;
        {err_total, total_checks} = 0;
        void'($urandom(32'h2a6a));
        repeat (6) @(negedge i_clk);
        i_nrst = 1'b1;
        for (int k = 0; k < 9; k++) begin
            {v, sp, ae, pm} = 4'(k); // last pass: vanished request
            {lt, es, a, up, lv} = 16'($urandom);
            vias_host_inst.wr(1'b0, {a, 1'b1, lt, sp, 2'b11});
            vias_host_inst.wr(1'b1, up);
            vias_host_inst.wr(1'b1, {6'h00, ae, pm});
            vias_host_inst.wr(1'b1, 8'h01 << lv);
            vias_host_inst.rd(1'b1, q);
            `CHK(q, 8'h01 << lv)
            req[lv] = 1'b1;
            repeat (3) @(negedge i_clk);
            ce = 1'b0; // a frozen block must drop this unmask write
            vias_host_inst.wr(1'b1, 8'h00);
            ce = 1'b1;
            repeat (2) @(negedge i_clk);
            `CHK(o_int, 1'b0)
            vias_host_inst.wr(1'b1, 8'h00);
            repeat (3) @(negedge i_clk);
            `CHK(o_int, 1'b1)
            vias_host_inst.rd(1'b0, q);
            `CHK(q[lv], 1'b1)
            if (v) req = 8'h00;
            vias_host_inst.ack(q, oe);
            req = 8'h00; // held through the first pulse
            if (pm) `CHK(oe, 1'b1) else `CHK(q, 8'hcd)
            vias_host_inst.ack(q, oe);
            if (pm) `CHK(q, {up[7:3], lv}) else `CHK(q, lo(a, sp, v ? 3'h7 : lv))
            if (!pm) begin
                vias_host_inst.ack(q, oe);
                `CHK(q, up)
            end
            `CHK(o_int, v & ~lt)
            vias_host_inst.wr(1'b0, 8'h0b);
            vias_host_inst.rd(1'b0, q);
            `CHK(q, (v | ae) ? 8'h00 : 8'h01 << lv)
            vias_host_inst.wr(1'b0, {1'b0, es, 3'b100, es ? lv : 3'h0});
            vias_host_inst.rd(1'b0, q);
            `CHK(q, 8'h00)
            vias_host_inst.wr(1'b0, 8'h0a);
            vias_host_inst.rd(1'b0, q);
            if (!v) `CHK(q, 8'h00)
        end
        complete_run();
    end
endmodule : tb
bind vias_top vias_chk #(.NUM_LEVELS(NUM_LEVELS)) vias_chk_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n),
    .i_acknowledge_strobe_n(i_acknowledge_strobe_n), .i_request_inputs(i_request_inputs),
    .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_int(o_int));
`default_nettype wire
